// >>> hdl/tom_thermal.sv
// thermal overload estimator top: step timer, first-order update, memory, enables
//
// Overview of operation
// - every 500 ms compute difference of squared current and previous state
// - scale difference by 0.5 s over active time constant in seconds
// - add scaled increment to state; new state replaces old
// - report thermal state as percentage of trip level
// - trip asserts when state reaches square of maximum sustained current
// - alarm at trip level times alarm percent; clears below 0.95 of it
// - heating constant with current; cooling constant below 0.1 A positive sequence
// - state survives supply loss; memory setting chooses stored start or zero
// - no pickup threshold; function always picked up
// - thermal reset input clears memorized state
// - enable input puts function in service; no internal default, must be tied high when unused
// - drive indication of enabled or disabled status
`timescale 1ns/1ps
module tom_thermal
#(
	parameter int STEP_CYCLES = tom_pkg::STEP_CYCLES,
	parameter int CUR_W = tom_pkg::CUR_W,
	parameter int STATE_W = tom_pkg::STATE_W
)
(
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [CUR_W-1:0] I_RMS,
	input wire logic [CUR_W-1:0] I_POS_SEQ_MA,
	input wire logic [tom_pkg::TAU_W-1:0] TAU_HEAT_S,
	input wire logic [tom_pkg::TAU_W-1:0] TAU_COOL_S,
	input wire logic [CUR_W-1:0] IMAX,
	input wire logic [6:0] ALARM_PCT,
	input wire logic [6:0] RESET_PCT,
	input wire logic ENABLE_SET,
	input wire logic MEMORY_SET,
	input wire logic [STATE_W-1:0] STORED_THETA,
	input wire logic THERMAL_RESET_IN,
	input wire logic THERMAL_BLOCK_IN,
	input wire logic THERMAL_ENABLE_IN,
	output logic THERMAL_ALARM_OUT,
	output logic THERMAL_TRIP_OUT,
	output logic THERMAL_ENABLED_FLAG,
	output logic [STATE_W-1:0] THETA_OUT,
	output logic [15:0] THETA_PCT
);
	// ************************************************************
	// reset release
	// ************************************************************
	logic rst_s1_reg;
	logic rst_n_reg;
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_s1_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n_reg <= rst_s1_reg;
		end
	end
	wire rst_n = rst_n_reg;
	// ************************************************************
	// step timer
	// ************************************************************
	// no pull exists inside: an unused enable input must be tied high by the integrator
	wire enable_in = THERMAL_ENABLE_IN;
	wire active = ENABLE_SET && enable_in;
	logic [31:0] cnt_reg;
	logic step_reg;
	wire cnt_wrap = cnt_reg == 32'(STEP_CYCLES - 1);
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= 32'h0000_0000;
			step_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_wrap ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
			step_reg <= cnt_wrap;
		end
	end
	// ************************************************************
	// first-order update
	// ************************************************************
	logic [STATE_W-1:0] theta_reg;
	logic [STATE_W-1:0] theta_next;
	logic loaded_reg;
	wire cooling = I_POS_SEQ_MA < CUR_W'(tom_pkg::COOL_LIMIT_MA);
	wire [tom_pkg::TAU_W-1:0] tau_raw = cooling ? TAU_COOL_S : TAU_HEAT_S;
	// a zero constant is treated as one second so the divide never faults
	wire [tom_pkg::TAU_W-1:0] tau_s = (tau_raw == '0) ? 16'h0001 : tau_raw;
	wire [STATE_W-1:0] i_sq = STATE_W'(I_RMS * I_RMS);
	wire signed [STATE_W+1:0] diff = $signed({2'b00, i_sq}) - $signed({2'b00, theta_reg});
	// 0.5 s / tau = 5 / (10 * tau); truncation toward zero can leave a tiny residue on cooling
	// both operands stay signed, or a falling state would divide as a huge positive number
	wire signed [STATE_W+5:0] tau_x10 = $signed({{(STATE_W-10){1'b0}}, tau_s}) * 38'sd10;
	wire signed [STATE_W+5:0] div_tau = (diff * 38'sd5) / tau_x10;
	wire signed [STATE_W+5:0] sum = $signed({6'h00, theta_reg}) + div_tau;
	assign theta_next = sum[STATE_W+5] ? '0 : STATE_W'(sum);
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			theta_reg <= tom_pkg::STATE_RESET;
			loaded_reg <= 1'b0;
		end
		else if (THERMAL_RESET_IN)
		begin
			theta_reg <= tom_pkg::STATE_RESET;
			loaded_reg <= 1'b1;
		end
		else if (!loaded_reg)
		begin
			// stored state is taken after release, never under the async reset
			theta_reg <= MEMORY_SET ? STORED_THETA : tom_pkg::STATE_RESET;
			loaded_reg <= 1'b1;
		end
		else if (step_reg)
			theta_reg <= theta_next;
	end
	// ************************************************************
	// levels and outputs
	// ************************************************************
	tom_step_if step_bus();
	assign step_bus.tick = step_reg;
	assign step_bus.theta = theta_reg;
	tom_levels u_levels (
		.clk(MCLK),
		.rst_n(rst_n),
		.step(step_bus.lvl),
		.active(active),
		.blocked(THERMAL_BLOCK_IN),
		.imax(IMAX),
		.alarm_pct(ALARM_PCT),
		.reset_pct(RESET_PCT),
		.alarm(THERMAL_ALARM_OUT),
		.trip(THERMAL_TRIP_OUT)
	);
	wire [STATE_W-1:0] trip_lvl = STATE_W'(IMAX * IMAX);
	wire [STATE_W+6:0] pct_x = theta_reg * 7'(tom_pkg::PCT_FULL);
	wire [STATE_W+6:0] pct_q = (trip_lvl == '0) ? '0 : pct_x / trip_lvl;
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			THETA_PCT <= 16'h0000;
			THETA_OUT <= tom_pkg::STATE_RESET;
			THERMAL_ENABLED_FLAG <= 1'b0;
		end
		else
		begin
			THETA_PCT <= (pct_q > 39'h00_0000_FFFF) ? 16'hFFFF : 16'(pct_q);
			THETA_OUT <= theta_reg;
			THERMAL_ENABLED_FLAG <= active;
		end
	end
	step_period_a: assert property (@(posedge MCLK) disable iff (!rst_n)
		step_reg |=> !step_reg)
		else $error("update strobe longer than one cycle");
	reset_clear_a: assert property (@(posedge MCLK) disable iff (!rst_n)
		THERMAL_RESET_IN |=> theta_reg == '0)
		else $error("thermal reset did not clear state");
	enabled_flag_a: assert property (@(posedge MCLK) disable iff (!rst_n)
		(ENABLE_SET && THERMAL_ENABLE_IN) |=> THERMAL_ENABLED_FLAG)
		else $error("enabled flag wrong");
	hold_state_a: assert property (@(posedge MCLK) disable iff (!rst_n)
		(loaded_reg && !step_reg && !THERMAL_RESET_IN) |=> $stable(theta_reg))
		else $error("state changed outside an update");
	cool_rise_a: assert property (@(posedge MCLK) disable iff (!rst_n)
		(step_reg && loaded_reg && !THERMAL_RESET_IN && i_sq <= theta_reg) |=> theta_reg <= $past(theta_reg))
		else $error("state rose with current below state");
endmodule : tom_thermal

// >>> hdl/tom_pkg.sv
// package with constants and types for the thermal overload estimator
package tom_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_HZ = 125000000;
	localparam int STEP_MS = 500;
	localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
	// ************************************************************
	// fixed-point figures
	// ************************************************************
	localparam int CUR_W = 16;
	localparam int STATE_W = 32;
	localparam int PCT_FULL = 100;
	localparam int ALARM_HYST_NUM = 95;
	localparam int STEP_TENTHS = 5;
	localparam int COOL_LIMIT_MA = 100;
	localparam int TAU_W = 16;
	localparam logic [6:0] RESET_PCT_DEFAULT = 7'h50;
	localparam logic [6:0] ALARM_PCT_DEFAULT = 7'h32;
	localparam logic [STATE_W-1:0] STATE_RESET = 32'h0000_0000;
	typedef enum logic [1:0] {TOM_IDLE, TOM_CALC, TOM_CMP} tom_phase_e;
endpackage : tom_pkg

// >>> hdl/tom_step_if.sv
// interface carrying the step strobe and state between estimator and level logic
`timescale 1ns/1ps
interface tom_step_if;
	logic tick;
	logic [tom_pkg::STATE_W-1:0] theta;
	modport core (output tick, output theta);
	modport lvl (input tick, input theta);
endinterface : tom_step_if

// >>> hdl/tom_levels.sv
// alarm and trip level comparators with hysteresis
`timescale 1ns/1ps
module tom_levels
(
	input wire logic clk,
	input wire logic rst_n,
	tom_step_if.lvl step,
	input wire logic active,
	input wire logic blocked,
	input wire logic [tom_pkg::CUR_W-1:0] imax,
	input wire logic [6:0] alarm_pct,
	input wire logic [6:0] reset_pct,
	output logic alarm,
	output logic trip
);
	// ************************************************************
	// thresholds
	// ************************************************************
	wire [tom_pkg::STATE_W-1:0] trip_lvl = tom_pkg::STATE_W'(imax * imax);
	// percentages are applied by scaling the state up, so no threshold is rounded down early
	wire [47:0] theta_x100 = 48'(step.theta) * 48'(tom_pkg::PCT_FULL);
	wire [47:0] theta_x10k = theta_x100 * 48'(tom_pkg::PCT_FULL);
	wire [47:0] alarm_x = 48'(trip_lvl) * 48'(alarm_pct);
	wire [47:0] alarm_rst_x = alarm_x * 48'(tom_pkg::ALARM_HYST_NUM);
	wire [47:0] trip_rst_x = 48'(trip_lvl) * 48'(reset_pct);
	wire trip_set = step.theta >= trip_lvl;
	wire trip_clr = theta_x100 < trip_rst_x;
	wire alarm_set = theta_x100 >= alarm_x;
	wire alarm_clr = theta_x10k < alarm_rst_x;
	logic trip_next;
	logic alarm_next;
	// ************************************************************
	// output flags
	// ************************************************************
	// blocking before a trip stops operation; blocking after it resets the trip
	assign trip_next = !active || blocked ? 1'b0 : (trip_set ? 1'b1 : (trip_clr ? 1'b0 : trip));
	assign alarm_next = !active ? 1'b0 : (alarm_set ? 1'b1 : (alarm_clr ? 1'b0 : alarm));
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trip <= 1'b0;
			alarm <= 1'b0;
		end
		else
		begin
			trip <= trip_next;
			alarm <= alarm_next;
		end
	end
	trip_gate_a: assert property (@(posedge clk) disable iff (!rst_n) (!active || blocked) |=> !trip)
		else $error("trip set while inactive or blocked");
	trip_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		(active && !blocked && step.theta >= trip_lvl) |=> trip)
		else $error("trip missing at trip level");
	alarm_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(alarm && active && !$changed(step.theta) && theta_x10k >= alarm_rst_x) |=> alarm)
		else $error("alarm dropped inside hysteresis");
endmodule : tom_levels

// >>> test/tom_meas_model.sv
// behavioural model of the current measurement path feeding the estimator
`timescale 1ns/1ps
module tom_meas_model
(
	input wire logic clk,
	input wire logic [15:0] i_cmd,
	input wire logic [15:0] pos_cmd,
	output logic [15:0] i_rms,
	output logic [15:0] i_pos_ma
);
	// ************************************************************
	// measurement refresh
	// ************************************************************
	// figures appear one clock after the command, like a sampled front end
	always_ff @(posedge clk)
	begin
		i_rms <= i_cmd;
		i_pos_ma <= pos_cmd;
	end
endmodule : tom_meas_model

// >>> test/tom_thermal_tb.sv
// self-checking bench for the thermal overload estimator
`timescale 1ns/1ps
module tom_thermal_tb;
	localparam int STEP = 20;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] i_cmd = 16'h0010;
	logic [15:0] pos_cmd = 16'h01F4;
	logic [15:0] i_rms;
	logic [15:0] i_pos;
	logic [15:0] tau_h = 16'h0001;
	logic [15:0] tau_c = 16'h0002;
	logic [15:0] imax = 16'h000A;
	logic [6:0] apct = tom_pkg::ALARM_PCT_DEFAULT;
	logic [6:0] rpct = tom_pkg::RESET_PCT_DEFAULT;
	logic en_set = 1'b1;
	logic mem_set = 1'b0;
	logic [31:0] stored = 32'h0000_00C8;
	logic th_rst = 1'b0;
	logic blk = 1'b0;
	logic en_in = 1'b1;
	logic alarm;
	logic trip;
	logic en_flag;
	logic [31:0] theta;
	logic [15:0] pct;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;
	int eth = 0;
	logic etrip = 1'b0;
	logic ealarm = 1'b0;
	// ************************************************************
	// far side, design and clock
	// ************************************************************
	tom_meas_model meas (.clk(mclk), .i_cmd(i_cmd), .pos_cmd(pos_cmd), .i_rms(i_rms), .i_pos_ma(i_pos));
	tom_thermal #(.STEP_CYCLES(STEP)) dut (.MCLK(mclk), .RST_N(rst_n), .I_RMS(i_rms), .I_POS_SEQ_MA(i_pos),
		.TAU_HEAT_S(tau_h), .TAU_COOL_S(tau_c), .IMAX(imax), .ALARM_PCT(apct), .RESET_PCT(rpct),
		.ENABLE_SET(en_set), .MEMORY_SET(mem_set), .STORED_THETA(stored), .THERMAL_RESET_IN(th_rst),
		.THERMAL_BLOCK_IN(blk), .THERMAL_ENABLE_IN(en_in), .THERMAL_ALARM_OUT(alarm),
		.THERMAL_TRIP_OUT(trip), .THERMAL_ENABLED_FLAG(en_flag), .THETA_OUT(theta), .THETA_PCT(pct));
	always #4 mclk = ~mclk;
	// ************************************************************
	// checking tasks
	// ************************************************************
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	// one update period of the reference model, then compare all outputs
	task automatic step(input bit do_wait);
		int lvl;
		int tau;
		if (do_wait)
		begin
			repeat (STEP) @(posedge mclk);
			#1;
		end
		tau = (pos_cmd < 16'h0064) ? int'(tau_c) : int'(tau_h);
		eth = th_rst ? 0 : eth + (int'(i_cmd) * int'(i_cmd) - eth) * 5 / (10 * tau);
		lvl = int'(imax) * int'(imax);
		if (eth >= lvl)
			etrip = 1'b1;
		else if (eth * 100 < lvl * int'(rpct))
			etrip = 1'b0;
		if (blk)
			etrip = 1'b0;
		if (eth * 100 >= lvl * int'(apct))
			ealarm = 1'b1;
		else if (eth * 10000 < lvl * int'(apct) * 95)
			ealarm = 1'b0;
		check(theta, eth);
		check(pct, eth * 100 / lvl);
		check(trip, etrip & en_set & en_in);
		check(alarm, ealarm & en_set & en_in);
		check(en_flag, en_set & en_in);
	endtask : step
	// ************************************************************
	// timeout and main sequence
	// ************************************************************
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			end_sim();
		end
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		check(theta, 32'h0000_0000);
		// the strobe phase is unknown after reset, so lock onto the first update
		for (int k = 0; k < 3 * STEP && theta === 32'h0000_0000; k++)
		begin
			@(posedge mclk);
			#1;
		end
		step(0);
		i_cmd = 16'h0000;
		pos_cmd = 16'h0000;
		repeat (4) step(1);
		i_cmd = 16'h0010;
		pos_cmd = 16'h01F4;
		step(1);
		blk = 1'b1;
		repeat (2) step(1);
		blk = 1'b0;
		step(1);
		en_set = 1'b0;
		step(1);
		en_set = 1'b1;
		en_in = 1'b0;
		step(1);
		en_in = 1'b1;
		step(1);
		th_rst = 1'b1;
		step(1);
		th_rst = 1'b0;
		// reach the alarm level, then decay slowly into the hysteresis band and out of it
		i_cmd = 16'h000A;
		step(1);
		tau_h = 16'h000A;
		i_cmd = 16'h0000;
		repeat (2) step(1);
		mem_set = 1'b1;
		rst_n = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		check(theta, stored);
		check(pct, 16'h00C8);
		end_sim();
	end
endmodule : tom_thermal_tb
